// ===== core/fxu_pkg.sv
package fxu_pkg;
    // ----------------------------------------------------------------
    // datapath widths
    // ----------------------------------------------------------------
    localparam int GPR_WIDTH = 64;
    localparam int WORD_WIDTH = 32;
    localparam int CNT_WIDTH = 7;
    localparam int IMM_WIDTH = 16;
    localparam int FIELD_IDX_WIDTH = 3;
    localparam int GPR_IDX_WIDTH = 5;
    localparam int BUS_ADDR_WIDTH = 4;
    localparam int BUS_DATA_WIDTH = 32;

    // ----------------------------------------------------------------
    // instruction encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_CMP_SIGNED_IMM = 6'h0B;
    localparam logic [5:0] OP_CMP_UNSIGNED_IMM = 6'h0A;
    localparam logic [5:0] OP_EXTENDED = 6'h1F;
    localparam logic [9:0] XO_CMP_UNSIGNED_REG = 10'h020;
    localparam logic [9:0] XO_CLZ_DOUBLE = 10'h03A;
    localparam logic [9:0] XO_CLZ_WORD = 10'h01A;
    localparam logic [4:0] CLZ_DOUBLE_RSVD = 5'h00;

    // ----------------------------------------------------------------
    // condition field bit positions
    // ----------------------------------------------------------------
    localparam int CR_LT_POS = 0;
    localparam int CR_GT_POS = 1;
    localparam int CR_EQ_POS = 2;
    localparam int CR_SO_POS = 3;
    localparam logic [2:0] COND_FIELD_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] STATUS_OFFSET = 4'h0;
    localparam logic [3:0] MASK_OFFSET = 4'h4;
    localparam logic [3:0] CTRL_OFFSET = 4'h8;
    localparam logic [3:0] COUNT_OFFSET = 4'hC;
    localparam int EV_CMP_POS = 0;
    localparam int EV_CLZ_POS = 1;
    localparam int EV_ILLEGAL_POS = 2;
    localparam int EV_WIDTH = 3;
    localparam int CTRL_IMPL64_POS = 0;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic CTRL_IMPL64_RESET = 1'b1;

    typedef enum logic [1:0] {
        CMP_NONE = 2'b00,
        CMP_SIGNED_IMM = 2'b01,
        CMP_UNSIGNED_REG = 2'b10,
        CMP_UNSIGNED_IMM = 2'b11
    } cmp_kind_t;
endpackage : fxu_pkg

// ===== core/clz_if.sv
`timescale 1ns/1ps
`default_nettype none
interface clz_if #(
    parameter int WIDTH = 64,
    parameter int CW = 7
);
    logic [WIDTH-1:0] value;
    logic [CW-1:0] count;
    modport requester (output value, input count);
    modport counter (input value, output count);
endinterface : clz_if
`default_nettype wire

// ===== core/lead_zero_counter.sv
`timescale 1ns/1ps
`default_nettype none
module lead_zero_counter #(
    parameter int WIDTH = 64,
    parameter int CW = 7
) (
    clz_if.counter link
);
    import fxu_pkg::*;

    // scans from the top bit down; a word count feeds ones below the word
    function automatic logic [CW-1:0] count_zeros(input logic [WIDTH-1:0] v);
        logic [CW-1:0] n;
        logic hit;
        n = '0;
        hit = 1'b0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                hit = 1'b1;
            end else if (!hit) begin
                n = n + CW'(1);
            end
        end
        return n;
    endfunction : count_zeros

    assign link.count = count_zeros(link.value);
endmodule : lead_zero_counter
`default_nettype wire

// ===== core/fixed_point_compare_clz_unit.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_point_compare_clz_unit #(
    parameter int GW = fxu_pkg::GPR_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // issue side
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [GW-1:0] first_source_value,
    input wire logic [GW-1:0] second_source_value,
    input wire logic summary_overflow,
    // general register write-back
    output logic gpr_wr_en,
    output logic [fxu_pkg::GPR_IDX_WIDTH-1:0] gpr_wr_idx,
    output logic [GW-1:0] gpr_wr_data,
    // condition register write
    output logic cr_wr_en,
    output logic [fxu_pkg::FIELD_IDX_WIDTH-1:0] cr_wr_field,
    output logic [3:0] cr_wr_value,
    output logic illegal_instr,
    // register port
    input wire logic [fxu_pkg::BUS_ADDR_WIDTH-1:0] reg_addr,
    input wire logic [fxu_pkg::BUS_DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fxu_pkg::BUS_DATA_WIDTH-1:0] reg_rdata,
    output logic irq
);
    import fxu_pkg::*;

    // ----------------------------------------------------------------
    // instruction fields (bit 31 is the most significant)
    // ----------------------------------------------------------------
    function automatic logic [GW-1:0] extend_word(input logic [GW-1:0] v, input logic sgn);
        return {{(GW - WORD_WIDTH){sgn & v[WORD_WIDTH-1]}}, v[WORD_WIDTH-1:0]};
    endfunction : extend_word

    wire logic [5:0] primary_op = issue_instr[31:26];
    wire logic [FIELD_IDX_WIDTH-1:0] cr_target_field = issue_instr[25:23];
    wire logic size_bit = issue_instr[21];
    wire logic [GPR_IDX_WIDTH-1:0] count_target_gpr = issue_instr[20:16];
    wire logic [4:0] second_source_bits = issue_instr[15:11];
    wire logic [9:0] ext_op = issue_instr[10:1];
    wire logic [IMM_WIDTH-1:0] unsigned_imm = issue_instr[15:0];
    wire logic record_flag = issue_instr[0];

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [EV_WIDTH-1:0] status_q, status_d;
    logic [EV_WIDTH-1:0] mask_q;
    logic impl64_q;
    logic [CNT_WIDTH-1:0] last_count_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic is_extended = primary_op == OP_EXTENDED;
    wire logic dec_cmp_simm = primary_op == OP_CMP_SIGNED_IMM;
    wire logic dec_cmp_uimm = primary_op == OP_CMP_UNSIGNED_IMM;
    wire logic dec_cmp_ureg = is_extended && ext_op == XO_CMP_UNSIGNED_REG;
    wire logic dec_clz_dbl = is_extended && ext_op == XO_CLZ_DOUBLE
                             && second_source_bits == CLZ_DOUBLE_RSVD;
    wire logic dec_clz_word = is_extended && ext_op == XO_CLZ_WORD;

    cmp_kind_t cmp_kind;
    assign cmp_kind = dec_cmp_simm ? CMP_SIGNED_IMM :
                      dec_cmp_uimm ? CMP_UNSIGNED_IMM :
                      dec_cmp_ureg ? CMP_UNSIGNED_REG : CMP_NONE;

    // a 32-bit implementation refuses the doubleword count outright
    wire logic clz_dbl_refused = dec_clz_dbl && !impl64_q;
    wire logic clz_dbl_go = dec_clz_dbl && impl64_q;

    wire logic go_cmp = issue_valid && cmp_kind != CMP_NONE;
    wire logic go_clz = issue_valid && (clz_dbl_go || dec_clz_word);
    wire logic go_illegal = issue_valid && clz_dbl_refused;

    // ----------------------------------------------------------------
    // compare datapath
    // ----------------------------------------------------------------
    wire logic cmp_signed = cmp_kind == CMP_SIGNED_IMM;
    // a 32-bit machine always compares words, whatever the size bit says
    wire logic cmp_full = size_bit && impl64_q;
    wire logic [GW-1:0] imm_sext = {{(GW - IMM_WIDTH){unsigned_imm[IMM_WIDTH-1]}}, unsigned_imm};
    wire logic [GW-1:0] imm_zext = {{(GW - IMM_WIDTH){1'b0}}, unsigned_imm};
    wire logic [GW-1:0] cmp_rhs_raw = cmp_kind == CMP_SIGNED_IMM ? imm_sext :
                                      cmp_kind == CMP_UNSIGNED_IMM ? imm_zext :
                                      second_source_value;
    wire logic [GW-1:0] cmp_lhs = cmp_full ? first_source_value
                                  : extend_word(first_source_value, cmp_signed);
    wire logic [GW-1:0] cmp_rhs = cmp_full ? cmp_rhs_raw
                                  : extend_word(cmp_rhs_raw, cmp_signed);

    wire logic cmp_eq = cmp_lhs == cmp_rhs;
    wire logic cmp_lt = cmp_signed ? ($signed(cmp_lhs) < $signed(cmp_rhs))
                                   : (cmp_lhs < cmp_rhs);
    wire logic cmp_gt = !cmp_lt && !cmp_eq;

    logic [3:0] cmp_field;
    always_comb begin
        cmp_field = 4'h0;
        cmp_field[CR_LT_POS] = cmp_lt;
        cmp_field[CR_GT_POS] = cmp_gt;
        cmp_field[CR_EQ_POS] = cmp_eq;
        cmp_field[CR_SO_POS] = summary_overflow;
    end

    // ----------------------------------------------------------------
    // leading zero count
    // ----------------------------------------------------------------
    clz_if #(.WIDTH(GW), .CW(CNT_WIDTH)) clz_link ();

    // ones below the low word cap the word count at 32
    assign clz_link.value = dec_clz_word
                            ? {first_source_value[WORD_WIDTH-1:0], {(GW - WORD_WIDTH){1'b1}}}
                            : first_source_value;

    lead_zero_counter #(.WIDTH(GW), .CW(CNT_WIDTH)) u_clz (
        .link(clz_link.counter)
    );

    wire logic [CNT_WIDTH-1:0] clz_count = clz_link.count;
    wire logic [GW-1:0] clz_result = {{(GW - CNT_WIDTH){1'b0}}, clz_count};

    // the count is never negative, so the lt bit always reads clear
    logic [3:0] clz_field;
    always_comb begin
        clz_field = 4'h0;
        clz_field[CR_LT_POS] = 1'b0;
        clz_field[CR_GT_POS] = clz_count != '0;
        clz_field[CR_EQ_POS] = clz_count == '0;
        clz_field[CR_SO_POS] = summary_overflow;
    end

    // ----------------------------------------------------------------
    // result registers; no path reaches the exception register
    // ----------------------------------------------------------------
    wire logic cr_wr_d = go_cmp || (go_clz && record_flag);
    wire logic [FIELD_IDX_WIDTH-1:0] cr_field_d = go_cmp ? cr_target_field
                                                  : COND_FIELD_ZERO;
    wire logic [3:0] cr_value_d = go_cmp ? cmp_field : clz_field;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpr_wr_en <= 1'b0;
            gpr_wr_idx <= '0;
            gpr_wr_data <= '0;
            cr_wr_en <= 1'b0;
            cr_wr_field <= '0;
            cr_wr_value <= 4'h0;
            illegal_instr <= 1'b0;
        end else begin
            gpr_wr_en <= go_clz;
            gpr_wr_idx <= go_clz ? count_target_gpr : gpr_wr_idx;
            gpr_wr_data <= go_clz ? clz_result : gpr_wr_data;
            cr_wr_en <= cr_wr_d;
            cr_wr_field <= cr_wr_d ? cr_field_d : cr_wr_field;
            cr_wr_value <= cr_wr_d ? cr_value_d : cr_wr_value;
            illegal_instr <= go_illegal;
        end
    end

    // ----------------------------------------------------------------
    // register port and interrupt
    // ----------------------------------------------------------------
    wire logic sel_status = reg_addr == STATUS_OFFSET;
    wire logic sel_mask = reg_addr == MASK_OFFSET;
    wire logic sel_ctrl = reg_addr == CTRL_OFFSET;
    wire logic sel_count = reg_addr == COUNT_OFFSET;

    logic [EV_WIDTH-1:0] events;
    always_comb begin
        events = '0;
        events[EV_CMP_POS] = go_cmp;
        events[EV_CLZ_POS] = go_clz;
        events[EV_ILLEGAL_POS] = go_illegal;
    end

    // a new event in the clearing cycle survives the read
    wire logic status_clear = reg_rd && sel_status;
    assign status_d = (status_clear ? '0 : status_q) | events;

    wire logic [BUS_DATA_WIDTH-1:0] rd_mux =
        sel_status ? {{(BUS_DATA_WIDTH - EV_WIDTH){1'b0}}, status_q} :
        sel_mask ? {{(BUS_DATA_WIDTH - EV_WIDTH){1'b0}}, mask_q} :
        sel_ctrl ? {{(BUS_DATA_WIDTH - 1){1'b0}}, impl64_q} :
        sel_count ? {{(BUS_DATA_WIDTH - CNT_WIDTH){1'b0}}, last_count_q} : '0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RESET;
            mask_q <= MASK_RESET;
            impl64_q <= CTRL_IMPL64_RESET;
            last_count_q <= '0;
            reg_rdata <= '0;
            irq <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= (reg_wr && sel_mask) ? reg_wdata[EV_WIDTH-1:0] : mask_q;
            impl64_q <= (reg_wr && sel_ctrl) ? reg_wdata[CTRL_IMPL64_POS] : impl64_q;
            last_count_q <= go_clz ? clz_count : last_count_q;
            reg_rdata <= reg_rd ? rd_mux : '0;
            irq <= |(status_d & mask_q);
        end
    end
endmodule : fixed_point_compare_clz_unit
`default_nettype wire

// ===== test/cond_reg_model.sv
`timescale 1ns/1ps
`default_nettype none
module cond_reg_model
    import fxu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cr_wr_en,
    input wire logic [fxu_pkg::FIELD_IDX_WIDTH-1:0] cr_wr_field,
    input wire logic [3:0] cr_wr_value,
    output logic [31:0] cr_q
);
    // ------------------------------------------------------------
    // condition register, eight 4-bit fields
    // ------------------------------------------------------------
    // only the addressed nibble moves, so a stray field write shows up in cr_q
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_q <= 32'h0;
        end else if (cr_wr_en) begin
            cr_q[{cr_wr_field, 2'b00} +: 4] <= cr_wr_value;
        end
    end
endmodule : cond_reg_model
`default_nettype wire

// ===== test/fixed_point_compare_clz_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_point_compare_clz_unit_assertions
    import fxu_pkg::*;
#(
    parameter int GW = fxu_pkg::GPR_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [GW-1:0] first_source_value,
    input wire logic [GW-1:0] second_source_value,
    input wire logic summary_overflow,
    input wire logic gpr_wr_en,
    input wire logic [fxu_pkg::GPR_IDX_WIDTH-1:0] gpr_wr_idx,
    input wire logic [GW-1:0] gpr_wr_data,
    input wire logic cr_wr_en,
    input wire logic [fxu_pkg::FIELD_IDX_WIDTH-1:0] cr_wr_field,
    input wire logic [3:0] cr_wr_value,
    input wire logic illegal_instr,
    input wire logic [fxu_pkg::BUS_ADDR_WIDTH-1:0] reg_addr,
    input wire logic [fxu_pkg::BUS_DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fxu_pkg::BUS_DATA_WIDTH-1:0] reg_rdata,
    input wire logic irq
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_cmp_field_so: assert property (issue_valid && issue_instr[31:26] == OP_CMP_SIGNED_IMM |=> cr_wr_en
        && cr_wr_field == $past(issue_instr[25:23]) && cr_wr_value[3] == $past(summary_overflow)) else $error("bad field");
    a_cr_onehot: assert property (cr_wr_en |-> $onehot(cr_wr_value[2:0])) else $error("bad cond bits");
    a_cmp_eq_reg: assert property (issue_valid && issue_instr[31:26] == OP_EXTENDED
        && issue_instr[10:1] == XO_CMP_UNSIGNED_REG && first_source_value == second_source_value
        |=> cr_wr_value[2:0] == 3'h4) else $error("equal not flagged");
    a_clz_record: assert property (gpr_wr_en && cr_wr_en |-> cr_wr_field == 3'h0 && !cr_wr_value[0]
        && cr_wr_value[2] == (gpr_wr_data == 0)) else $error("bad count record");
    a_word_count: assert property (issue_valid && issue_instr[31:26] == OP_EXTENDED
        && issue_instr[10:1] == XO_CLZ_WORD |=> gpr_wr_en && gpr_wr_idx == $past(issue_instr[20:16])
        && gpr_wr_data <= 32) else $error("bad word count");
    a_double_range: assert property (gpr_wr_en |-> gpr_wr_data <= 64) else $error("count too large");
    a_double_fate: assert property (issue_valid && issue_instr[31:26] == OP_EXTENDED
        && issue_instr[10:1] == XO_CLZ_DOUBLE && issue_instr[15:11] == 5'h00
        |=> illegal_instr != gpr_wr_en) else $error("double count lost");
    a_illegal_quiet: assert property (illegal_instr |-> !cr_wr_en) else $error("illegal wrote field");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule : fixed_point_compare_clz_unit_assertions
bind fixed_point_compare_clz_unit fixed_point_compare_clz_unit_assertions #(.GW(GW)) chk_inst (.ref_clk, .rst_n,
    .issue_valid, .issue_instr, .first_source_value, .second_source_value, .summary_overflow, .gpr_wr_en,
    .gpr_wr_idx, .gpr_wr_data, .cr_wr_en, .cr_wr_field, .cr_wr_value, .illegal_instr, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq);
`default_nettype wire

// ===== test/fixed_point_compare_clz_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_point_compare_clz_unit_bench;
    import fxu_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0;
    logic [63:0] first_source_value = 64'h0;
    logic [63:0] second_source_value = 64'h0;
    logic summary_overflow = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic gpr_wr_en, cr_wr_en, illegal_instr, irq;
    logic [4:0] gpr_wr_idx;
    logic [63:0] gpr_wr_data;
    logic [2:0] cr_wr_field;
    logic [3:0] cr_wr_value;
    logic [31:0] reg_rdata, cr_q;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    fixed_point_compare_clz_unit fixed_point_compare_clz_unit_inst (.ref_clk, .rst_n, .issue_valid, .issue_instr,
        .first_source_value, .second_source_value, .summary_overflow, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data,
        .cr_wr_en, .cr_wr_field, .cr_wr_value, .illegal_instr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq);
    cond_reg_model cond_reg_model_inst (.ref_clk, .rst_n, .cr_wr_en, .cr_wr_field, .cr_wr_value, .cr_q);
    // ------------------------------------------------------------
    // encoders and access tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] mk_cmp(logic [5:0] op, logic [2:0] bf, logic l, logic [15:0] lo);
        return {op, bf, 1'b0, l, 5'h04, lo};
    endfunction : mk_cmp
    function automatic logic [31:0] mk_x(logic [4:0] ra, logic [9:0] xo, logic rc);
        return {OP_EXTENDED, 5'h03, ra, 5'h00, xo, rc};
    endfunction : mk_x
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic so);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        first_source_value <= a;
        second_source_value <= b;
        summary_overflow <= so;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        #1;
    endtask : op
    task automatic cx(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic so,
                      input logic [2:0] f, input logic [3:0] v);
        op(ins, a, b, so);
        chk(cr_wr_en, 1'b1);
        chk(cr_wr_field, f);
        chk(cr_wr_value, v);
        chk(gpr_wr_en, 1'b0);
    endtask : cx
    task automatic zx(input logic [31:0] ins, input logic [63:0] a, input logic so, input logic [6:0] n,
                      input logic [3:0] v);
        op(ins, a, 64'h0, so);
        chk(gpr_wr_en, 1'b1);
        chk(gpr_wr_idx, ins[20:16]);
        chk(gpr_wr_data, {57'h0, n});
        chk(cr_wr_en, ins[0]);
        if (ins[0]) begin
            chk(cr_wr_value, v);
        end
    endtask : zx
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // a hang costs a mismatch rather than a silent stall
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        cx(mk_cmp(OP_CMP_SIGNED_IMM, 3'h5, 1'b1, 16'h0011), 64'hFFFFFFFFFFFFFFE7, 64'h0, 1'b1, 3'h5, 4'h9);
        cx(mk_cmp(OP_CMP_SIGNED_IMM, 3'h7, 1'b0, 16'hFFFF), 64'h00000001FFFFFFFF, 64'h0, 1'b0, 3'h7, 4'h4);
        cx(mk_cmp(OP_EXTENDED, 3'h2, 1'b1, {5'h05, XO_CMP_UNSIGNED_REG, 1'b0}), 64'hFFFF0000, 64'h7FFF0000,
           1'b0, 3'h2, 4'h2);
        cx(mk_cmp(OP_CMP_UNSIGNED_IMM, 3'h0, 1'b1, 16'h00FF), 64'hFF, 64'h0, 1'b0, 3'h0, 4'h4);
        cx(mk_cmp(OP_CMP_UNSIGNED_IMM, 3'h3, 1'b1, 16'h8000), 64'h7FFF, 64'h0, 1'b0, 3'h3, 4'h1);
        cx(mk_cmp(OP_EXTENDED, 3'h6, 1'b1, {5'h05, XO_CMP_UNSIGNED_REG, 1'b0}), 64'h5, 64'h5, 1'b0, 3'h6, 4'h4);
        @(posedge ref_clk);
        #1;
        chk(cr_q, 32'h44901204);
        chk(irq, 1'b0);
        $display("test compare done");
        zx(mk_x(5'h09, XO_CLZ_DOUBLE, 1'b1), 64'h1, 1'b0, 7'd63, 4'h2);
        zx(mk_x(5'h03, XO_CLZ_DOUBLE, 1'b1), 64'h0, 1'b1, 7'd64, 4'hA);
        zx(mk_x(5'h03, XO_CLZ_WORD, 1'b0), 64'h0FFFFFFF00619920, 1'b0, 7'd9, 4'h0);
        zx(mk_x(5'h0A, XO_CLZ_WORD, 1'b1), 64'h0000000080000000, 1'b1, 7'd0, 4'hC);
        zx(mk_x(5'h1F, XO_CLZ_WORD, 1'b1), 64'hFFFFFFFF00000000, 1'b0, 7'd32, 4'h2);
        op(mk_x(5'h04, XO_CLZ_DOUBLE, 1'b1) | 32'h800, 64'h1, 64'h0, 1'b0);
        chk(gpr_wr_en | cr_wr_en | illegal_instr, 1'b0);
        $display("test count done");
        wr(COUNT_OFFSET, 32'h0);
        rd(COUNT_OFFSET, 32'h20);
        rd(STATUS_OFFSET, 32'h3);
        rd(STATUS_OFFSET, 32'h0);
        rd(CTRL_OFFSET, 32'h1);
        rd(4'h2, 32'h0);
        $display("test registers done");
        wr(MASK_OFFSET, 32'h4);
        wr(CTRL_OFFSET, 32'h0);
        // size bit held at zero while in the 32-bit setting
        cx(mk_cmp(OP_CMP_UNSIGNED_IMM, 3'h1, 1'b0, 16'h0001), 64'h100000000, 64'h0, 1'b0, 3'h1, 4'h1);
        op(mk_x(5'h08, XO_CLZ_DOUBLE, 1'b1), 64'h1, 64'h0, 1'b0);
        chk(illegal_instr, 1'b1);
        chk(gpr_wr_en | cr_wr_en, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(irq, 1'b1);
        rd(STATUS_OFFSET, 32'h5);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(irq, 1'b0);
        $display("test interrupt done");
        final_report();
    end
endmodule : fixed_point_compare_clz_unit_bench
`default_nettype wire
